// *** logic/fsbra_regs.svh ***
// Constants for the request/address phase: widths, field positions, timing counts
// Assumes inclusion by bare name from the package and both ends
`ifndef FSBRA_REGS_SVH
`define FSBRA_REGS_SVH

`define FSBRA_ADDR_W 33
`define FSBRA_ADDR_LSB 3
`define FSBRA_ADDR_MSB 35
`define FSBRA_REQ_W 5
`define FSBRA_PAR_W 2
`define FSBRA_STB_W 2
`define FSBRA_HI_LSB 21
`define FSBRA_BIT20_POS 17
`define FSBRA_STB0_ADDR_W 14
`define FSBRA_CLK_PERIOD_NS 4
`define FSBRA_SETUP_NS 16
`define FSBRA_SETUP_CYC ((`FSBRA_SETUP_NS + `FSBRA_CLK_PERIOD_NS - 1) / `FSBRA_CLK_PERIOD_NS)
`define FSBRA_STRAP_HOLD_NS 16
`define FSBRA_STRAP_HOLD_CYC ((`FSBRA_STRAP_HOLD_NS + `FSBRA_CLK_PERIOD_NS - 1) / `FSBRA_CLK_PERIOD_NS)
`define FSBRA_CNT_W 4
`define FSBRA_STRAP_MASK 33'h1FFFFFFFF

`endif

// *** logic/fsbra_pkg.sv ***
// Types shared by both ends of the request/address phase
// Assumes fsbra_regs.svh is on the include path
`include "fsbra_regs.svh"

package fsbra_pkg;
    typedef logic [`FSBRA_ADDR_W-1:0] fsbra_addr_t;
    typedef logic [`FSBRA_REQ_W-1:0] fsbra_req_t;
    typedef logic [`FSBRA_PAR_W-1:0] fsbra_par_t;
    typedef logic [`FSBRA_CNT_W-1:0] fsbra_cnt_t;
    typedef enum logic [2:0] {
        FSBRA_IDLE,
        FSBRA_SUB1_SETUP,
        FSBRA_SUB1_HOLD,
        FSBRA_SUB2_SETUP,
        FSBRA_SUB2_HOLD
    } fsbra_state_t;

    // Parity pin levels for one subphase; a pin is high for an even count of asserted lines
    function automatic fsbra_par_t fsbra_parity(input fsbra_addr_t a, input fsbra_req_t r,
                                                input logic second);
        logic hi;
        logic lo;
        hi = ^a[`FSBRA_ADDR_W-1:`FSBRA_HI_LSB];
        lo = (^a[`FSBRA_HI_LSB-1:0]) ^ (^r);
        if (second) begin
            fsbra_parity = {~hi, ~lo};
        end else begin
            fsbra_parity = {~lo, ~hi};
        end
    endfunction
endpackage

// *** logic/fsbra_if.sv ***
// Request/address phase wires between requesting processor and receiving agent
// Assumes open-drain wired-AND address lines with pull-ups; all pins active low
`timescale 1ns/1ps
`default_nettype none
`include "fsbra_regs.svh"

interface fsbra_if;
    logic [`FSBRA_ADDR_W-1:0] rq_addr_n_out;
    logic rq_addr_oe;
    logic [`FSBRA_ADDR_W-1:0] rc_addr_n_out;
    logic rc_addr_oe;
    logic [`FSBRA_ADDR_W-1:0] addr_n;
    logic [`FSBRA_REQ_W-1:0] req_n;
    logic [`FSBRA_PAR_W-1:0] request_parity_n;
    logic [`FSBRA_STB_W-1:0] addr_capture_strobe_n;
    logic request_valid_strobe_n;

    assign addr_n = (rq_addr_oe ? rq_addr_n_out : {`FSBRA_ADDR_W{1'b1}})
                  & (rc_addr_oe ? rc_addr_n_out : {`FSBRA_ADDR_W{1'b1}});

    modport requester (
        output rq_addr_n_out, rq_addr_oe, req_n, request_parity_n,
        output addr_capture_strobe_n, request_valid_strobe_n,
        input addr_n
    );
    modport receiver (
        output rc_addr_n_out, rc_addr_oe,
        input addr_n, req_n, request_parity_n, addr_capture_strobe_n, request_valid_strobe_n
    );
endinterface
`default_nettype wire

// *** logic/fsbra_receiver.sv ***
// Receiving agent end: strobe capture of both subphases, parity check, strap drive
// Assumes the requester holds each subphase stable for the setup count around each edge
`timescale 1ns/1ps
`default_nettype none
`include "fsbra_regs.svh"

module fsbra_receiver
    import fsbra_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_n_in,
    fsbra_if.receiver bus,
    input wire fsbra_addr_t strap_in,
    output logic req_seen_out,
    output logic rx_valid_out,
    output fsbra_addr_t rx_addr_out,
    output fsbra_req_t rx_type_out,
    output fsbra_addr_t rx_attr_out,
    output fsbra_req_t rx_type2_out,
    output logic rx_parity_err_out
);
    localparam int VW = `FSBRA_ADDR_W + `FSBRA_REQ_W + `FSBRA_PAR_W + `FSBRA_STB_W + 1;
    localparam fsbra_cnt_t STRAP_CYC = fsbra_cnt_t'(`FSBRA_STRAP_HOLD_CYC);

    logic [VW-1:0] sync1_ff;
    logic [VW-1:0] sync2_ff;
    fsbra_addr_t s_addr;
    fsbra_req_t s_req;
    fsbra_par_t s_par;
    logic [`FSBRA_STB_W-1:0] s_stb;
    logic s_ads;
    logic [`FSBRA_STB_W-1:0] stb_prev_ff;
    logic [`FSBRA_STB_W-1:0] fall;
    logic [`FSBRA_STB_W-1:0] rise;
    fsbra_addr_t a1_ff;
    fsbra_addr_t a2_ff;
    fsbra_req_t r1_ff;
    fsbra_req_t r2_ff;
    fsbra_par_t p1_ff;
    fsbra_par_t p2_ff;
    logic armed_ff;
    logic done_ff;
    logic [`FSBRA_STB_W-1:0] got2_ff;
    logic ads_prev_ff;
    fsbra_cnt_t strap_cnt_ff;
    logic strap_oe_ff;
    fsbra_addr_t strap_ff;

    // Every pin passes two flip-flops before use
    always_ff @(posedge clk_in) begin
        sync1_ff <= {bus.addr_n, bus.req_n, bus.request_parity_n,
                     bus.addr_capture_strobe_n, bus.request_valid_strobe_n};
        sync2_ff <= sync1_ff;
    end

    assign {s_addr, s_req, s_par, s_stb, s_ads} = sync2_ff;

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            stb_prev_ff <= {`FSBRA_STB_W{1'b1}};
            ads_prev_ff <= 1'b1;
        end else begin
            stb_prev_ff <= s_stb;
            ads_prev_ff <= s_ads;
        end
    end

    assign fall = stb_prev_ff & ~s_stb;
    assign rise = ~stb_prev_ff & s_stb;

    // Falling edge takes subphase 1, rising edge subphase 2, per strobe group
    genvar g;
    generate
        for (g = 0; g < `FSBRA_STB_W; g++) begin : g_grp
            localparam int LO = (g == 0) ? 0 : `FSBRA_STB0_ADDR_W;
            localparam int HI = (g == 0) ? `FSBRA_STB0_ADDR_W - 1 : `FSBRA_ADDR_W - 1;
            always_ff @(posedge clk_in) begin
                if (!rst_n_in) begin
                    a1_ff[HI:LO] <= '0;
                    a2_ff[HI:LO] <= '0;
                end else if (fall[g]) begin
                    a1_ff[HI:LO] <= ~s_addr[HI:LO];
                end else if (rise[g]) begin
                    a2_ff[HI:LO] <= ~s_addr[HI:LO];
                end
            end
        end
    endgenerate

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            r1_ff <= '0;
            r2_ff <= '0;
            p1_ff <= '0;
            p2_ff <= '0;
        end else if (fall[0]) begin
            r1_ff <= ~s_req;
            p1_ff <= s_par;
        end else if (rise[0]) begin
            r2_ff <= ~s_req;
            p2_ff <= s_par;
        end
    end

    // Valid strobe arms a new transaction
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            armed_ff <= 1'b0;
            got2_ff <= '0;
            done_ff <= 1'b0;
            req_seen_out <= 1'b0;
        end else begin
            req_seen_out <= ads_prev_ff & ~s_ads;
            done_ff <= armed_ff && (&(got2_ff | rise)) && !(ads_prev_ff && !s_ads);
            if (ads_prev_ff && !s_ads) begin
                armed_ff <= 1'b1;
                got2_ff <= '0;
            end else if (armed_ff && (&(got2_ff | rise))) begin
                armed_ff <= 1'b0;
                got2_ff <= '0;
            end else if (armed_ff) begin
                got2_ff <= got2_ff | rise;
            end
        end
    end

    // Both subphases handed over together with the parity result
    // Handover waits one cycle: subphase 2 registers load on the completing edge
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rx_valid_out <= 1'b0;
            rx_addr_out <= '0;
            rx_type_out <= '0;
            rx_attr_out <= '0;
            rx_type2_out <= '0;
            rx_parity_err_out <= 1'b0;
        end else begin
            rx_valid_out <= done_ff;
            if (done_ff) begin
                rx_addr_out <= a1_ff;
                rx_type_out <= r1_ff;
                rx_attr_out <= a2_ff;
                rx_type2_out <= r2_ff;
                rx_parity_err_out <= (fsbra_parity(a1_ff, r1_ff, 1'b0) != p1_ff)
                                   || (fsbra_parity(a2_ff, r2_ff, 1'b1) != p2_ff);
            end
        end
    end

    // Strap values driven during reset and briefly after release
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            strap_cnt_ff <= STRAP_CYC;
            strap_oe_ff <= 1'b1;
        end else if (strap_cnt_ff != '0) begin
            strap_cnt_ff <= strap_cnt_ff - fsbra_cnt_t'(1);
        end else begin
            strap_oe_ff <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            strap_ff <= strap_in;
        end
    end

    assign bus.rc_addr_n_out = ~(strap_ff & `FSBRA_STRAP_MASK);
    assign bus.rc_addr_oe = strap_oe_ff;
endmodule
`default_nettype wire

// *** logic/fsbra_requester.sv ***
// Requesting processor end: drives address and type subphases with strobes and parity
// Assumes the receiving agent captures on strobe edges and drives straps around reset
`timescale 1ns/1ps
`default_nettype none
`include "fsbra_regs.svh"

module fsbra_requester
    import fsbra_pkg::*;
#(
    parameter int SETUP_CYC = `FSBRA_SETUP_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    fsbra_if.requester bus,
    input wire logic req_start_in,
    input wire fsbra_addr_t req_addr_in,
    input wire fsbra_req_t req_type_in,
    input wire fsbra_addr_t req_attr_in,
    input wire fsbra_req_t req_type2_in,
    input wire logic bit20_mask_in,
    input wire logic real_mode_in,
    output logic req_ready_out,
    output logic req_done_out,
    output fsbra_addr_t lookup_addr_out,
    output fsbra_addr_t power_on_cfg_out,
    output logic cfg_valid_out
);
    localparam fsbra_cnt_t PHASE_LAST = fsbra_cnt_t'(SETUP_CYC - 1);

    fsbra_state_t state_ff;
    fsbra_state_t nxt_state;
    fsbra_cnt_t cnt_ff;
    fsbra_cnt_t nxt_cnt;
    fsbra_addr_t addr_ff;
    fsbra_req_t type_ff;
    fsbra_addr_t attr_ff;
    fsbra_req_t type2_ff;
    fsbra_addr_t pin_addr_ff;
    fsbra_req_t pin_req_ff;
    fsbra_par_t pin_par_ff;
    logic [`FSBRA_STB_W-1:0] pin_stb_ff;
    logic pin_ads_ff;
    logic pin_oe_ff;
    logic mask1_ff;
    logic mask2_ff;
    logic [`FSBRA_ADDR_W-1:0] cfg1_ff;
    logic [`FSBRA_ADDR_W-1:0] cfg2_ff;
    logic in_reset_ff;
    fsbra_addr_t masked_addr;
    logic phase_end;

    // Mask input is asynchronous, two flip-flops before use
    always_ff @(posedge clk_in) begin
        mask1_ff <= bit20_mask_in;
        mask2_ff <= mask1_ff;
    end

    // Bit 20 cleared only while masked in real mode
    always_comb begin
        masked_addr = req_addr_in;
        if (mask2_ff && real_mode_in) begin
            masked_addr[`FSBRA_BIT20_POS] = 1'b0;
        end
    end

    // Address lines synchronised for strap capture
    always_ff @(posedge clk_in) begin
        cfg1_ff <= bus.addr_n;
        cfg2_ff <= cfg1_ff;
    end

    // Straps taken on the first edge after reset release
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            in_reset_ff <= 1'b1;
            power_on_cfg_out <= '0;
            cfg_valid_out <= 1'b0;
        end else begin
            in_reset_ff <= 1'b0;
            if (in_reset_ff) begin
                power_on_cfg_out <= ~cfg2_ff & `FSBRA_STRAP_MASK;
                cfg_valid_out <= 1'b1;
            end
        end
    end

    assign phase_end = (cnt_ff == PHASE_LAST);
    assign req_ready_out = (state_ff == FSBRA_IDLE) && !in_reset_ff;

    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        case (state_ff)
            FSBRA_IDLE: begin
                nxt_cnt = '0;
                if (req_start_in && req_ready_out) begin
                    nxt_state = FSBRA_SUB1_SETUP;
                end
            end
            FSBRA_SUB1_SETUP: begin
                nxt_cnt = phase_end ? '0 : cnt_ff + fsbra_cnt_t'(1);
                if (phase_end) begin
                    nxt_state = FSBRA_SUB1_HOLD;
                end
            end
            FSBRA_SUB1_HOLD: begin
                nxt_cnt = phase_end ? '0 : cnt_ff + fsbra_cnt_t'(1);
                if (phase_end) begin
                    nxt_state = FSBRA_SUB2_SETUP;
                end
            end
            FSBRA_SUB2_SETUP: begin
                nxt_cnt = phase_end ? '0 : cnt_ff + fsbra_cnt_t'(1);
                if (phase_end) begin
                    nxt_state = FSBRA_SUB2_HOLD;
                end
            end
            FSBRA_SUB2_HOLD: begin
                nxt_cnt = phase_end ? '0 : cnt_ff + fsbra_cnt_t'(1);
                if (phase_end) begin
                    nxt_state = FSBRA_IDLE;
                end
            end
            default: begin
                nxt_state = FSBRA_IDLE;
                nxt_cnt = '0;
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_ff <= FSBRA_IDLE;
            cnt_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
        end
    end

    // Request captured at acceptance; masked address also feeds cache lookup
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_ff <= '0;
            type_ff <= '0;
            attr_ff <= '0;
            type2_ff <= '0;
            lookup_addr_out <= '0;
        end else if (req_start_in && req_ready_out) begin
            addr_ff <= masked_addr;
            type_ff <= req_type_in;
            attr_ff <= req_attr_in;
            type2_ff <= req_type2_in;
            lookup_addr_out <= masked_addr;
        end
    end

    // Pin drive: subphase 1 address and type, subphase 2 attributes and second type, with parity
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_addr_ff <= {`FSBRA_ADDR_W{1'b1}};
            pin_req_ff <= {`FSBRA_REQ_W{1'b1}};
            pin_par_ff <= {`FSBRA_PAR_W{1'b1}};
            pin_oe_ff <= 1'b0;
        end else begin
            case (nxt_state)
                FSBRA_SUB1_SETUP, FSBRA_SUB1_HOLD: begin
                    pin_addr_ff <= ~addr_sel(1'b0);
                    pin_req_ff <= ~req_sel(1'b0);
                    pin_par_ff <= fsbra_parity(addr_sel(1'b0), req_sel(1'b0), 1'b0);
                    pin_oe_ff <= 1'b1;
                end
                FSBRA_SUB2_SETUP, FSBRA_SUB2_HOLD: begin
                    pin_addr_ff <= ~attr_ff;
                    pin_req_ff <= ~type2_ff;
                    pin_par_ff <= fsbra_parity(attr_ff, type2_ff, 1'b1);
                    pin_oe_ff <= 1'b1;
                end
                default: begin
                    pin_addr_ff <= {`FSBRA_ADDR_W{1'b1}};
                    pin_req_ff <= {`FSBRA_REQ_W{1'b1}};
                    pin_par_ff <= {`FSBRA_PAR_W{1'b1}};
                    pin_oe_ff <= 1'b0;
                end
            endcase
        end
    end

    // Subphase 1 uses the request just accepted or the held copy
    function automatic fsbra_addr_t addr_sel(input logic dummy);
        addr_sel = (state_ff == FSBRA_IDLE) ? masked_addr : addr_ff;
    endfunction

    function automatic fsbra_req_t req_sel(input logic dummy);
        req_sel = (state_ff == FSBRA_IDLE) ? req_type_in : type_ff;
    endfunction

    // Strobe falls mid subphase 1, rises mid subphase 2; valid strobe spans subphase 1
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            pin_stb_ff <= {`FSBRA_STB_W{1'b1}};
            pin_ads_ff <= 1'b1;
            req_done_out <= 1'b0;
        end else begin
            pin_stb_ff <= (nxt_state == FSBRA_SUB1_HOLD || nxt_state == FSBRA_SUB2_SETUP)
                        ? {`FSBRA_STB_W{1'b0}} : {`FSBRA_STB_W{1'b1}};
            pin_ads_ff <= !(nxt_state == FSBRA_SUB1_SETUP || nxt_state == FSBRA_SUB1_HOLD);
            req_done_out <= (state_ff == FSBRA_SUB2_HOLD) && phase_end;
        end
    end

    assign bus.rq_addr_n_out = pin_addr_ff;
    assign bus.rq_addr_oe = pin_oe_ff;
    assign bus.req_n = pin_req_ff;
    assign bus.request_parity_n = pin_par_ff;
    assign bus.addr_capture_strobe_n = pin_stb_ff;
    assign bus.request_valid_strobe_n = pin_ads_ff;
endmodule
`default_nettype wire

// *** dv/fsbra_assertions.sv ***
// Wire checks on the request/address interface between the two ends
// Assumes the bench instantiates it beside the interface, on the shared clock and reset
`timescale 1ns/1ps
`default_nettype none
`include "fsbra_regs.svh"

module fsbra_assertions (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic rq_addr_oe,
    input wire logic rc_addr_oe,
    input wire logic [`FSBRA_ADDR_W-1:0] addr_n,
    input wire logic [`FSBRA_REQ_W-1:0] req_n,
    input wire logic [`FSBRA_PAR_W-1:0] request_parity_n,
    input wire logic [`FSBRA_STB_W-1:0] addr_capture_strobe_n,
    input wire logic request_valid_strobe_n
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rst_n_in);

    // Pin levels for upper group and for lower group plus type
    logic par_hi;
    logic par_lo;
    assign par_hi = ~^(~addr_n[32:21]);
    assign par_lo = ~^{~addr_n[20:0], ~req_n};

    chk_sub1_parity: assert property (
        $fell(addr_capture_strobe_n[0]) |-> request_parity_n == {par_lo, par_hi})
        else $error("parity wrong at first subphase");
    chk_sub2_parity: assert property (
        $rose(addr_capture_strobe_n[0]) |-> request_parity_n == {par_hi, par_lo})
        else $error("parity wrong at second subphase");
    chk_strobe_pair: assert property (
        addr_capture_strobe_n[0] == addr_capture_strobe_n[1])
        else $error("strobes differ");
    chk_valid_arms: assert property (
        $fell(request_valid_strobe_n) |-> addr_capture_strobe_n[0]
        ##[1:8] ($fell(addr_capture_strobe_n[0]) && !request_valid_strobe_n))
        else $error("no strobe fall after valid");
    chk_sub1_hold: assert property (
        $fell(addr_capture_strobe_n[0]) |-> ($stable(addr_n) && $stable(req_n))
        ##1 ($stable(addr_n) && $stable(req_n)))
        else $error("first subphase moved at strobe");
    chk_sub2_hold: assert property (
        $rose(addr_capture_strobe_n[0]) |-> ($stable(addr_n) && $stable(req_n))
        ##1 ($stable(addr_n) && $stable(req_n)))
        else $error("second subphase moved at strobe");
    chk_sub2_turn: assert property (
        $fell(addr_capture_strobe_n[0]) |->
        ##[1:8] ($rose(request_valid_strobe_n) && !addr_capture_strobe_n[0]))
        else $error("no second subphase");
    chk_idle_after: assert property (
        $rose(addr_capture_strobe_n[0]) |->
        ##[1:8] (!rq_addr_oe && (&req_n) && (&request_parity_n)))
        else $error("pins not idle after request");
    chk_frame_drive: assert property (
        !request_valid_strobe_n |-> rq_addr_oe && !rc_addr_oe)
        else $error("address not driven by requester");
    chk_strobe_armed: assert property (
        $fell(addr_capture_strobe_n[0]) |-> !request_valid_strobe_n)
        else $error("strobe without valid");
endmodule
`default_nettype wire

// *** dv/test_fsb_request_address_phase.sv ***
// Bench joining requester and receiver through one interface
// Assumes package, header and interface compile first
`timescale 1ns/1ps
`default_nettype none
`include "fsbra_regs.svh"

module test_fsb_request_address_phase
    import fsbra_pkg::*;
;
    localparam int S = 3;
    typedef struct packed {
        fsbra_addr_t addr;
        fsbra_req_t typ;
        fsbra_addr_t attr;
        fsbra_req_t typ2;
    } fsbra_note_t;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic req_start_in = 1'b0;
    logic bit20_mask_in = 1'b0;
    logic real_mode_in = 1'b0;
    fsbra_addr_t req_addr_in = '0;
    fsbra_addr_t req_attr_in = '0;
    fsbra_addr_t strap_in = '0;
    fsbra_req_t req_type_in = '0;
    fsbra_req_t req_type2_in = '0;
    logic req_ready_out, req_done_out, cfg_valid_out, req_seen_out, rx_valid_out;
    logic rx_parity_err_out;
    fsbra_addr_t lookup_addr_out, power_on_cfg_out, rx_addr_out, rx_attr_out;
    fsbra_req_t rx_type_out, rx_type2_out;
    int n_mismatch = 0;
    int checks_done = 0;
    int n_seen = 0;
    int n_sent = 0;
    logic [31:0] rng = 32'h00000063;
    logic [31:0] r1;
    fsbra_note_t note, head;
    fsbra_note_t notes[$];

    fsbra_if bus();
    always #2 clk_in = ~clk_in;

    fsbra_requester #(.SETUP_CYC(S)) u_fsbra_requester (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .bus(bus), .req_start_in(req_start_in), .req_addr_in(req_addr_in),
        .req_type_in(req_type_in), .req_attr_in(req_attr_in), .req_type2_in(req_type2_in),
        .bit20_mask_in(bit20_mask_in), .real_mode_in(real_mode_in),
        .req_ready_out(req_ready_out), .req_done_out(req_done_out),
        .lookup_addr_out(lookup_addr_out), .power_on_cfg_out(power_on_cfg_out),
        .cfg_valid_out(cfg_valid_out));
    fsbra_receiver u_fsbra_receiver (.clk_in(clk_in), .rst_n_in(rst_n_in), .bus(bus),
        .strap_in(strap_in), .req_seen_out(req_seen_out), .rx_valid_out(rx_valid_out),
        .rx_addr_out(rx_addr_out), .rx_type_out(rx_type_out), .rx_attr_out(rx_attr_out),
        .rx_type2_out(rx_type2_out), .rx_parity_err_out(rx_parity_err_out));
    fsbra_assertions u_fsbra_assertions (.clk_in(clk_in), .rst_n_in(rst_n_in),
        .rq_addr_oe(bus.rq_addr_oe), .rc_addr_oe(bus.rc_addr_oe), .addr_n(bus.addr_n),
        .req_n(bus.req_n), .request_parity_n(bus.request_parity_n),
        .addr_capture_strobe_n(bus.addr_capture_strobe_n),
        .request_valid_strobe_n(bus.request_valid_strobe_n));

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        xs = x ^ (x << 5);
    endfunction

    task automatic chk(input string what, input logic [32:0] exp, input logic [32:0] got);
        checks_done++;
        if (exp !== got) begin
            n_mismatch++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic hang(input string what);
        n_mismatch++;
        $display("ERROR %s expected pulse seen none", what);
        end_of_test();
    endtask

    // One request; optional start pulse while busy must be ignored
    task automatic do_req(input fsbra_note_t n, input logic msk, input logic rm, input logic poke);
        fsbra_addr_t exp_addr;
        int k;
        exp_addr = n.addr;
        if (msk && rm) begin
            exp_addr[`FSBRA_BIT20_POS] = 1'b0;
        end
        bit20_mask_in <= msk;
        real_mode_in <= rm;
        req_addr_in <= n.addr;
        req_type_in <= n.typ;
        req_attr_in <= n.attr;
        req_type2_in <= n.typ2;
        repeat (4) @(posedge clk_in);
        notes.push_back({exp_addr, n.typ, n.attr, n.typ2});
        n_sent++;
        req_start_in <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_in);
            k++;
            if (k > 50) hang("req_ready_out");
        end while (req_ready_out !== 1'b1);
        req_start_in <= 1'b0;
        k = 0;
        if (poke) begin
            @(posedge clk_in);
            req_start_in <= 1'b1;
            @(posedge clk_in);
            req_start_in <= 1'b0;
            k = 2;
        end
        do begin
            @(posedge clk_in);
            k++;
            if (k > 4 * S + 6) hang("req_done_out");
        end while (req_done_out !== 1'b1);
        chk("req_done_out early", 33'h1, 33'(k >= 4 * S));
        chk("lookup_addr_out", exp_addr, lookup_addr_out);
    endtask

    // Compares each received request with the oldest note
    always @(posedge clk_in) begin
        if (rst_n_in === 1'b1 && req_seen_out === 1'b1) begin
            n_seen++;
        end
        if (rst_n_in === 1'b1 && rx_valid_out === 1'b1) begin
            if (notes.size() == 0) begin
                chk("rx_valid_out", 33'h0, 33'h1);
            end else begin
                head = notes.pop_front();
                chk("rx_addr_out", head.addr, rx_addr_out);
                chk("rx_type_out", 33'(head.typ), 33'(rx_type_out));
                chk("rx_attr_out", head.attr, rx_attr_out);
                chk("rx_type2_out", 33'(head.typ2), 33'(rx_type2_out));
                chk("rx_parity_err_out", 33'h0, 33'(rx_parity_err_out));
            end
        end
    end

    initial begin
        rng = xs(rng);
        strap_in = {rng[3], xs(rng)};
        repeat (12) @(posedge clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        chk("cfg_valid_out", 33'h1, 33'(cfg_valid_out));
        chk("power_on_cfg_out", strap_in, power_on_cfg_out);
        $display("test strap_sample done");
        repeat (8) @(posedge clk_in);
        for (int i = 0; i < 10; i++) begin
            rng = xs(rng);
            r1 = rng;
            rng = xs(rng);
            note.addr = {r1[0], rng};
            note.typ = r1[5:1];
            rng = xs(rng);
            r1 = rng;
            rng = xs(rng);
            note.attr = {r1[0], rng};
            note.typ2 = r1[5:1];
            if (i == 0) note = '1;
            if (i == 1) note = '0;
            do_req(note, ~i[1], ~i[0], i == 2);
            $display("test request %0d done", i);
        end
        for (int k = 0; k < 100 && notes.size() > 0; k++) @(posedge clk_in);
        if (notes.size() > 0) hang("rx_valid_out");
        chk("req_seen_out count", 33'(n_sent), 33'(n_seen));
        end_of_test();
    end
endmodule
`default_nettype wire
